// >>> logic/smsp_top.v
`timescale 1ns/1ps
`include "smsp_map.vh"

module smsp_top (
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire cpu_irq_global_en,
	input wire irq_vector_ack,
	output wire xfer_irq,
	input wire sck_in,
	output reg sck_out,
	output wire sck_oe,
	input wire mosi_in,
	output wire mosi_out,
	output wire mosi_oe,
	input wire miso_in,
	output wire miso_out,
	output wire miso_oe,
	input wire ss_n_in,
	output wire ss_n_out,
	output wire ss_n_oe
);

	// ********************
	// Functions
	// ********************

	// Address to register code, shared by read and write paths
	function [2:0] reg_code;
		input [3:0] addr;
		begin
			case (addr)
				`SMSP_OFF_CTRL: reg_code = `SMSP_REG_CTRL;
				`SMSP_OFF_STAT: reg_code = `SMSP_REG_STAT;
				`SMSP_OFF_DATA: reg_code = `SMSP_REG_DATA;
				`SMSP_OFF_PINS: reg_code = `SMSP_REG_PINS;
				default: reg_code = `SMSP_REG_NONE;
			endcase
		end
	endfunction

	// Shift one received bit in at the end opposite to the outgoing bit
	function [7:0] shift_in;
		input [7:0] sh;
		input bit_in;
		input lsb_first;
		begin
			if (lsb_first)
				shift_in = {bit_in, sh[7:1]};
			else
				shift_in = {sh[6:0], bit_in};
		end
	endfunction

	// ********************
	// State
	// ********************
	reg [7:0] ctrl;
	reg dbl;
	reg xfer_done_flag;
	reg write_collision_flag;
	reg arm_clear;
	reg [4:0] pins;
	reg [7:0] shreg;
	reg [7:0] rx_buf;
	reg rx_bit;
	reg [3:0] edge_cnt;
	reg m_active;
	reg sck_prev;
	reg aw_hold;
	reg [3:0] aw_addr_q;
	reg w_hold;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg [7:0] next_rx;
	reg done;
	wire m_tick;

	// ********************
	// Mode decode
	// ********************
	wire enabled = ctrl[`SMSP_CTL_EN];
	wire master = ctrl[`SMSP_CTL_ROLE];
	wire clock_idle_level = ctrl[`SMSP_CTL_IDLE];
	wire clock_phase_select = ctrl[`SMSP_CTL_PHASE];
	wire lsb_first = ctrl[`SMSP_CTL_LSB];
	wire ss_is_out = pins[`SMSP_PIN_SS_OE];

	// Select low while master with select as input means another master took the bus
	wire ss_conflict = enabled & master & ~ss_is_out & ~ss_n_in;
	wire slave_sel = enabled & ~master & ~ss_n_in;

	// SCK is only sampled as data here, never used as a clock; peer must stay at or below a quarter rate
	wire s_edge = slave_sel & (sck_in != sck_prev);
	wire ev = (m_active & m_tick) | s_edge;
	wire leading = ~edge_cnt[0];
	wire sample_ev = ev & (leading ^ clock_phase_select);
	wire setup_ev = ev & ~(leading ^ clock_phase_select);
	wire last_edge = (edge_cnt == `SMSP_LAST_EDGE);
	wire rx_pin = master ? miso_in : mosi_in;
	wire busy = m_active | (slave_sel & (edge_cnt != 4'h0));

	// ********************
	// Bus decode
	// ********************
	wire wr_do = aw_hold & w_hold & ~s_axi_bvalid;
	wire [2:0] wr_code = reg_code(aw_addr_q);
	wire wr_lane = w_strb_q[0];
	wire rd_do = s_axi_arvalid & s_axi_arready;
	wire [2:0] rd_code = reg_code(s_axi_araddr);
	wire data_wr = wr_do & (wr_code == `SMSP_REG_DATA) & wr_lane;
	wire data_acc = data_wr | (rd_do & (rd_code == `SMSP_REG_DATA));
	wire collide = data_wr & busy;
	wire load = data_wr & ~busy;

	assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	// ********************
	// Master bit clock
	// ********************
	smsp_rate_gen u_rate (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(m_active),
		.sel({dbl, ctrl[`SMSP_CTL_RATE_HI], ctrl[`SMSP_CTL_RATE_LO]}),
		.tick(m_tick)
	);

	// ********************
	// Pin drive
	// ********************

	// Data out is the edge bit of the shift register; both ends see the same bit
	wire out_bit = lsb_first ? shreg[0] : shreg[7];
	assign mosi_out = out_bit;
	assign miso_out = out_bit;
	// Slave forces MOSI, SCK, select to input; master forces MISO to input
	assign mosi_oe = enabled & master & pins[`SMSP_PIN_MOSI_OE];
	assign sck_oe = enabled & master & pins[`SMSP_PIN_SCK_OE];
	assign miso_oe = slave_sel & pins[`SMSP_PIN_MISO_OE];
	// Select stays a plain output only while master
	assign ss_n_oe = enabled & master & ss_is_out;
	assign ss_n_out = pins[`SMSP_PIN_SS_LVL];
	assign xfer_irq = ctrl[`SMSP_CTL_IRQ_EN] & xfer_done_flag & cpu_irq_global_en;

	// ********************
	// Byte completion decode
	// ********************
	always @* begin
		next_rx = shreg;
		done = 1'b0;
		if (sample_ev & last_edge) begin
			next_rx = shift_in(shreg, rx_pin, lsb_first);
			done = 1'b1;
		end else if (setup_ev & last_edge) begin
			next_rx = shift_in(shreg, rx_bit, lsb_first);
			done = 1'b1;
		end
	end

	// ********************
	// Shift engine
	// ********************

	// Sample edges latch the pin, setup edges shift it in; with clock_phase_select set, the last edge captures and shifts at once
	always @(posedge aclk) begin
		if (!aresetn) begin
			shreg <= 8'h00;
			rx_buf <= 8'h00;
			rx_bit <= 1'b0;
			edge_cnt <= 4'h0;
			m_active <= 1'b0;
			sck_out <= 1'b0;
			sck_prev <= 1'b0;
		end else begin
			sck_prev <= sck_in;
			if (!m_active)
				sck_out <= clock_idle_level;
			else if (m_tick)
				sck_out <= ~sck_out;
			if (ss_conflict) begin
				m_active <= 1'b0;
				edge_cnt <= 4'h0;
			end else if (!m_active && !slave_sel) begin
				edge_cnt <= 4'h0;
				if (load) begin
					shreg <= s_axi_wdata_byte(w_data_q);
					m_active <= enabled & master;
				end
			end else if (load) begin
				shreg <= s_axi_wdata_byte(w_data_q);
			end else if (ev) begin
				edge_cnt <= edge_cnt + 4'h1;
				if (sample_ev)
					rx_bit <= rx_pin;
				if (done) begin
					shreg <= next_rx;
					rx_buf <= next_rx;
					m_active <= 1'b0;
				end else if (setup_ev && edge_cnt != 4'h0) begin
					shreg <= shift_in(shreg, rx_bit, lsb_first);
				end
			end
		end
	end

	// Low byte of the bus word carries the data register
	function [7:0] s_axi_wdata_byte;
		input [31:0] d;
		begin
			s_axi_wdata_byte = d[7:0];
		end
	endfunction

	// ********************
	// Flags
	// ********************

	// A new event in the clearing cycle wins over the clear
	always @(posedge aclk) begin
		if (!aresetn) begin
			xfer_done_flag <= 1'b0;
			write_collision_flag <= 1'b0;
			arm_clear <= 1'b0;
		end else begin
			if (done || ss_conflict)
				xfer_done_flag <= 1'b1;
			else if (irq_vector_ack || (data_acc && arm_clear))
				xfer_done_flag <= 1'b0;
			if (collide)
				write_collision_flag <= 1'b1;
			else if (data_acc && arm_clear)
				write_collision_flag <= 1'b0;
			// Status read with a flag up arms the clear; the data access fires it
			if (rd_do && rd_code == `SMSP_REG_STAT)
				arm_clear <= xfer_done_flag | write_collision_flag;
			else if (data_acc)
				arm_clear <= 1'b0;
		end
	end

	// ********************
	// Control and configuration registers
	// ********************
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `SMSP_CTL_RESET;
			dbl <= 1'b0;
			pins <= `SMSP_PIN_RESET;
		end else begin
			if (wr_do && wr_lane) begin
				if (wr_code == `SMSP_REG_CTRL)
					ctrl <= w_data_q[7:0];
				if (wr_code == `SMSP_REG_STAT)
					dbl <= w_data_q[`SMSP_ST_DBL];
				if (wr_code == `SMSP_REG_PINS)
					pins <= w_data_q[4:0];
			end
			// Hardware clear beats a same-cycle software write; only software sets it again
			if (ss_conflict)
				ctrl[`SMSP_CTL_ROLE] <= 1'b0;
		end
	end

	// ********************
	// AXI4-Lite write channel
	// ********************

	// Address and data are held separately so either may arrive first
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			aw_addr_q <= 4'h0;
			w_hold <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SMSP_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_code == `SMSP_REG_NONE) ? `SMSP_RESP_SLVERR : `SMSP_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ********************
	// AXI4-Lite read channel
	// ********************

	// Reserved status bits and unmapped reads give zero
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `SMSP_RESP_OKAY;
		end else if (rd_do) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `SMSP_RESP_OKAY;
			case (rd_code)
				`SMSP_REG_CTRL: s_axi_rdata <= {24'h000000, ctrl};
				`SMSP_REG_STAT: s_axi_rdata <= {24'h000000, xfer_done_flag, write_collision_flag, 5'h00, dbl};
				`SMSP_REG_DATA: s_axi_rdata <= {24'h000000, rx_buf};
				`SMSP_REG_PINS: s_axi_rdata <= {27'h0000000, pins};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SMSP_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// >>> logic/smsp_map.vh
// Function
// - Slave select is always input as slave; low activates port; MISO drives only if configured.
// - Slave select high makes slave passive, resets bit counter, drops partial byte.
// - Master with slave select as output: pin is plain output, port ignores it.
// - Master with slave select as input: low level clears master bit, becomes slave.
// - That forced exit from master mode also sets transfer-complete flag.
// - Control bit 7 enables interrupt; request needs it, flag and global enable.
// - Control bit 6 enables the port; no serial operation without it.
// - Control bit 5 set shifts least significant bit first, else most significant.
// - Control bit 4 selects master; hardware clears it on slave select conflict.
// - Control bit 3 sets clock idle level and thus leading edge direction.
// - Control bit 2 zero samples on leading edge; one samples on trailing edge.
// - Modes 0..3 from polarity and phase; output and sampling use opposite edges.
// - Master rate selects divide clock by 4, 16, 64, 128; no slave effect.
// - Status bit 0 doubles rate: divisors 2, 8, 32, 64.
// - Status bit 7 sets on every finished byte and on slave select conflict.
// - Flag clears on interrupt vector, or status read with flag then data access.
// - Status bit 6 sets on data write during transfer; clears only on status read with flag then data access, not on vector.
// - Status bits 5 to 1 always read zero.
// - Data write loads shift register and starts; data read returns receive buffer.
// - Master data write runs eight bits, stops clock, sets flag, keeps byte.
// - Transmit single buffered, receive double buffered; unread byte is overwritten.
// - Slave forces MOSI, SCK, select to input; master forces MISO to input.
`ifndef SMSP_MAP_VH
`define SMSP_MAP_VH

// ********************
// Register offsets
// ********************
`define SMSP_OFF_CTRL 4'h0
`define SMSP_OFF_STAT 4'h4
`define SMSP_OFF_DATA 4'h8
`define SMSP_OFF_PINS 4'hc

// ********************
// Decoded register codes
// ********************
`define SMSP_REG_CTRL 3'h0
`define SMSP_REG_STAT 3'h1
`define SMSP_REG_DATA 3'h2
`define SMSP_REG_PINS 3'h3
`define SMSP_REG_NONE 3'h7

// ********************
// Control fields
// ********************
`define SMSP_CTL_IRQ_EN 7
`define SMSP_CTL_EN 6
`define SMSP_CTL_LSB 5
`define SMSP_CTL_ROLE 4
`define SMSP_CTL_IDLE 3
`define SMSP_CTL_PHASE 2
`define SMSP_CTL_RATE_HI 1
`define SMSP_CTL_RATE_LO 0
`define SMSP_CTL_RESET 8'h00

// ********************
// Status fields
// ********************
`define SMSP_ST_DONE 7
`define SMSP_ST_COLL 6
`define SMSP_ST_DBL 0

// ********************
// Pin configuration fields
// ********************
`define SMSP_PIN_MOSI_OE 0
`define SMSP_PIN_MISO_OE 1
`define SMSP_PIN_SCK_OE 2
`define SMSP_PIN_SS_OE 3
`define SMSP_PIN_SS_LVL 4
`define SMSP_PIN_RESET 5'h10

// ********************
// Half SCK period in clocks, index {double, rate_hi, rate_lo}
// ********************
`define SMSP_HALF_0 6'h02
`define SMSP_HALF_1 6'h08
`define SMSP_HALF_2 6'h20
`define SMSP_HALF_3 6'h40
`define SMSP_HALF_4 6'h01
`define SMSP_HALF_5 6'h04
`define SMSP_HALF_6 6'h10
`define SMSP_HALF_7 6'h20

// ********************
// Bus responses and counts
// ********************
`define SMSP_RESP_OKAY 2'h0
`define SMSP_RESP_SLVERR 2'h2
`define SMSP_LAST_EDGE 4'hf

`endif

// >>> logic/smsp_rate_gen.v
`timescale 1ns/1ps
`include "smsp_map.vh"

module smsp_rate_gen (
	input wire aclk,
	input wire aresetn,
	input wire run,
	input wire [2:0] sel,
	output reg tick
);

	reg [5:0] cnt;
	reg [5:0] half;

	// Half period lookup; double speed halves every divisor
	always @* begin
		case (sel)
			3'h0: half = `SMSP_HALF_0;
			3'h1: half = `SMSP_HALF_1;
			3'h2: half = `SMSP_HALF_2;
			3'h3: half = `SMSP_HALF_3;
			3'h4: half = `SMSP_HALF_4;
			3'h5: half = `SMSP_HALF_5;
			3'h6: half = `SMSP_HALF_6;
			default: half = `SMSP_HALF_7;
		endcase
	end

	// One pulse per half SCK period; counter restarts from zero on each run
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 6'h00;
			tick <= 1'b0;
		end else if (!run) begin
			cnt <= 6'h00;
			tick <= 1'b0;
		end else if (cnt == half - 6'h01) begin
			cnt <= 6'h00;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 6'h01;
			tick <= 1'b0;
		end
	end

endmodule

// >>> tb/smsp_asserts.sv
`timescale 1ns/1ps
// ****
// Port checks
// ****
module smsp_asserts (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awready,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire cpu_irq_global_en,
	input wire irq_vector_ack,
	input wire xfer_irq,
	input wire sck_oe,
	input wire mosi_oe,
	input wire miso_oe,
	input wire ss_n_in,
	input wire ss_n_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_irq_gate; xfer_irq |-> cpu_irq_global_en; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
	property p_irq_ack; irq_vector_ack |=> !xfer_irq; endproperty
	a_irq_ack: assert property (p_irq_ack) else $error("irq kept after vector ack");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("write response repeated");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_rupper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready; endproperty
	a_rupper: assert property (p_rupper) else $error("read upper bits or arready wrong");
	property p_wblock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_wblock: assert property (p_wblock) else $error("write taken during response");
	property p_master_miso; sck_oe |-> !miso_oe; endproperty
	a_master_miso: assert property (p_master_miso) else $error("miso driven as master");
	property p_slave_pins; miso_oe |-> !(sck_oe || mosi_oe || ss_n_oe); endproperty
	a_slave_pins: assert property (p_slave_pins) else $error("slave drives input pin");
	property p_passive; ss_n_in && $past(ss_n_in) |-> !miso_oe; endproperty
	a_passive: assert property (p_passive) else $error("miso driven while deselected");
endmodule
bind smsp_top smsp_asserts smsp_asserts_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .cpu_irq_global_en(cpu_irq_global_en),
	.irq_vector_ack(irq_vector_ack), .xfer_irq(xfer_irq), .sck_oe(sck_oe), .mosi_oe(mosi_oe),
	.miso_oe(miso_oe), .ss_n_in(ss_n_in), .ss_n_oe(ss_n_oe));

// >>> tb/smsp_peer.sv
`timescale 1ns/1ps
// ****
// Peer slave
// ****
module smsp_peer (
	input wire aclk,
	input wire ss_n,
	input wire sck,
	input wire mosi,
	input wire [1:0] mode,
	input wire lsb,
	input wire [7:0] tx,
	output wire miso,
	output reg [7:0] rx
);
	reg sck_q = 1'b0;
	reg mosi_q = 1'b0;
	reg wander = 1'b0;
	reg [2:0] n = 3'h0;
	// A setup edge moves the output at once, like a real slave, so even the fastest rate sees each bit in time
	wire setup_now = !ss_n && sck != sck_q && (sck != mode[1]) == mode[0];
	wire [2:0] cnt = n + {2'h0, setup_now};
	wire [2:0] i = mode[0] ? cnt - 3'h1 : cnt;
	// Released line wanders so stale bits never pass
	assign miso = ss_n ? wander : tx[lsb ? i : 3'h7 - i];
	// Sample edges take the data that stood before the edge, since the port may move it on that same clock
	always @(posedge aclk) begin
		sck_q <= sck;
		mosi_q <= mosi;
		wander <= ~wander;
		if (ss_n)
			n <= 3'h0;
		else if (sck != sck_q && (sck != mode[1]) == mode[0])
			n <= n + 3'h1;
		else if (sck != sck_q)
			rx <= lsb ? {mosi_q, rx[7:1]} : {rx[6:0], mosi_q};
	end
endmodule

// >>> tb/tb_spi_master_slave_port.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb_spi_master_slave_port;
	reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	reg gie = 0, ack = 0, tsck = 0, tmosi = 0, tss = 1, plsb = 0;
	reg [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
	reg [31:0] wdata = 0, q, seed = 21893;
	reg [1:0] pmode = 0, er = 0, rs;
	reg [7:0] ptx = 0, m, b, s;
	integer failures = 0, num_checks = 0, k, c, t;
	wire awready, wready, bvalid, arready, rvalid, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	wire ss_o, ss_oe, pmiso;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [7:0] prx;
	wire sck_w = sck_oe ? sck_o : tsck;
	wire mosi_w = mosi_oe ? mosi_o : tmosi;
	wire miso_w = miso_oe ? miso_o : pmiso;
	wire ss_w = ss_oe ? ss_o : tss;
	always #25 aclk = ~aclk;
	smsp_top smsp_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_irq_global_en(gie),
		.irq_vector_ack(ack), .xfer_irq(irq), .sck_in(sck_w), .sck_out(sck_o), .sck_oe(sck_oe),
		.mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_o),
		.miso_oe(miso_oe), .ss_n_in(ss_w), .ss_n_out(ss_o), .ss_n_oe(ss_oe));
	smsp_peer smsp_peer_i (.aclk(aclk), .ss_n(ss_w), .sck(sck_w), .mosi(mosi_w), .mode(pmode), .lsb(plsb),
		.tx(ptx), .miso(pmiso), .rx(prx));
	function [7:0] rnd;
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			rnd = seed[7:0];
		end
	endfunction
	// Half SCK period in clocks
	function integer hp(input [1:0] r, input d);
		hp = ((r == 2'h3) ? 64 : 2 << (2 * r)) >> d;
	endfunction
	task final_report;
		begin
			$display("checks %0d failures %0d", num_checks, failures);
			if (failures == 0 && num_checks > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			num_checks = num_checks + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("wrong value at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask
	// Handshakes judged at the falling edge, where ready is settled, acted on at the next rising edge
	task bus(input w, input [3:0] a, input [7:0] d);
		reg pa, pw, pb, ta, tw, tb;
		begin
			@(posedge aclk);
			pa = 1;
			pw = w;
			pb = 1;
			awaddr <= a;
			araddr <= a;
			wdata <= {24'h0, d};
			awvalid <= w;
			wvalid <= w;
			bready <= w;
			arvalid <= !w;
			rready <= !w;
			for (k = 0; k < 60 && (pa || pw || pb); k = k + 1) begin
				@(negedge aclk);
				ta = pa & (w ? awready : arready);
				tw = pw & wready;
				tb = pb & (w ? bvalid : rvalid);
				if (tb) begin
					q = rdata;
					rs = w ? bresp : rresp;
				end
				@(posedge aclk);
				if (ta) begin
					awvalid <= 0;
					arvalid <= 0;
				end
				if (tw)
					wvalid <= 0;
				if (tb) begin
					bready <= 0;
					rready <= 0;
				end
				pa = pa & ~ta;
				pw = pw & ~tw;
				pb = pb & ~tb;
			end
			if (pa || pw || pb) begin
				failures = failures + 1;
				final_report;
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			bus(1, a, d);
			chk({30'h0, rs}, {30'h0, er});
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			bus(0, a, 8'h0);
			chk(q, {24'h0, e});
			chk({30'h0, rs}, {30'h0, er});
		end
	endtask
	task wirq;
		begin
			for (c = 0; c < 3000 && irq !== 1'b1; c = c + 1)
				@(negedge aclk);
			if (c == 3000) begin
				failures = failures + 1;
				final_report;
			end
		end
	endtask
	// Mode change only with the peer deselected, so an idle-level change is no clock edge to it
	task cfg(input [7:0] ctl, input dbl);
		begin
			wr(4'hc, 8'h1d);
			wr(4'h4, {7'h0, dbl});
			wr(4'h0, ctl);
			pmode <= ctl[3:2];
			plsb <= ctl[5];
			wr(4'hc, 8'h0d);
		end
	endtask
	task xfer(input [7:0] ctl, input dbl);
		begin
			b = rnd();
			s = rnd();
			ptx <= s;
			cfg(ctl, dbl);
			wr(4'h8, b);
			wirq;
			chk({31'h0, c >= 16 * hp(ctl[1:0], dbl) - 3 && c <= 16 * hp(ctl[1:0], dbl) + 3}, 1);
			rd(4'h4, {dbl, 7'h0} | {7'h0, dbl} | 8'h80);
			bus(0, 4'h8, 8'h0);
			chk(q, {24'h0, s});
			chk({24'h0, prx}, {24'h0, b});
			rd(4'h4, {7'h0, dbl});
		end
	endtask
	// Bench as outside master, half period of four clocks, so well under a quarter rate
	task sbits(input [7:0] v, input integer n);
		integer j;
		begin
			@(posedge aclk);
			tss <= 0;
			for (j = 0; j < n; j = j + 1) begin
				tmosi <= v[7 - j];
				repeat (3) @(posedge aclk);
				@(negedge aclk);
				m = {m[6:0], miso_w};
				@(posedge aclk);
				tsck <= 1;
				repeat (4) @(posedge aclk);
				tsck <= 0;
			end
			repeat (4) @(posedge aclk);
			tss <= 1;
		end
	endtask
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		gie <= 1;
		wr(4'h4, 8'hff);
		rd(4'h4, 8'h01);
		// Unmapped offsets answer with an error response and read as zero
		er = 2'h2;
		wr(4'h1, 8'hff);
		rd(4'h2, 8'h00);
		er = 2'h0;
		for (t = 0; t < 8; t = t + 1)
			xfer(8'hd0 | {2'h0, t[2], 1'h0, t[1:0], 2'h0}, 0);
		for (t = 0; t < 8; t = t + 1)
			xfer(8'hd0 | (rnd() & 8'h2c) | {6'h0, t[1:0]}, t[2]);
		cfg(8'hd3, 0);
		b = rnd();
		wr(4'h8, b);
		wr(4'h8, ~b);
		wirq;
		rd(4'h4, 8'hc0);
		rd(4'h8, ptx);
		rd(4'h4, 8'h00);
		chk({24'h0, prx}, {24'h0, b});
		cfg(8'h93, 0);
		wr(4'h8, rnd());
		repeat (100) @(posedge aclk);
		rd(4'h4, 8'h00);
		wr(4'h0, 8'hd0);
		wr(4'hc, 8'h05);
		gie <= 0;
		tss <= 0;
		rd(4'h0, 8'hc0);
		chk({31'h0, irq}, 0);
		gie <= 1;
		rd(4'h4, 8'h80);
		@(negedge aclk);
		chk({31'h0, irq}, 1);
		@(posedge aclk);
		ack <= 1;
		@(posedge aclk);
		ack <= 0;
		rd(4'h4, 8'h00);
		rd(4'h0, 8'hc0);
		tss <= 1;
		wr(4'hc, 8'h02);
		wr(4'h0, 8'h40);
		b = rnd();
		s = rnd();
		sbits(rnd(), 4);
		// The cut frame has shifted the old byte, so software loads it again
		wr(4'h8, s);
		sbits(b, 8);
		chk({24'h0, m}, {24'h0, s});
		rd(4'h4, 8'h80);
		rd(4'h8, b);
		final_report;
	end
endmodule
